// *** core/sis_pkg.sv ***
// Constants shared by the interrupt and standby controller.
// Assumes a 32-bit APB slave with byte addresses.
package sis_pkg;
	localparam int ADDR_W = 8;
	localparam int NUM_SRC = 11;
	localparam int PRI_W = 4;
	// Register byte offsets
	localparam logic [7:0] OFS_RESET_CAUSE = 8'h00;
	localparam logic [7:0] OFS_PEND_LOW = 8'h04;
	localparam logic [7:0] OFS_PEND_MID = 8'h08;
	localparam logic [7:0] OFS_PEND_HIGH = 8'h0C;
	localparam logic [7:0] OFS_CONFIG = 8'h10;
	localparam logic [7:0] OFS_SRC_ENABLE = 8'h14;
	localparam logic [7:0] OFS_TIMEBASE = 8'h18;
	// Reset cause fields
	localparam int RC_POR = 0;
	localparam int RC_WATCHDOG = 1;
	localparam int RC_ILL_OPCODE = 2;
	localparam int RC_ILL_FETCH = 3;
	localparam int RC_MONITOR = 4;
	localparam int RC_LOW_VOLT = 5;
	localparam int RC_W = 6;
	localparam logic [RC_W-1:0] RC_RESET_VAL = 6'h01;
	// Config fields
	localparam int CFG_WD_DISABLE = 0;
	localparam int CFG_OSC_IN_STOP = 1;
	localparam int CFG_SHORT_REC = 2;
	// Timebase control fields
	localparam int TB_IRQ_EN = 0;
	localparam int TB_ACK = 1;
	localparam int TB_FLAG = 2;
	// Fixed priorities
	localparam logic [3:0] PRI_SWI = 4'h0;
	localparam logic [3:0] PRI_EXT_PIN = 4'h1;
	localparam logic [3:0] PRI_TIMEBASE = 4'hB;
	// Stop recovery lengths in reference clock cycles
	localparam int REC_LONG_CYCLES = 4096;
	localparam int REC_SHORT_CYCLES = 32;
	typedef enum logic [3:0] {
		S_RUN = 4'b0001,
		S_WAIT = 4'b0010,
		S_STOP = 4'b0100,
		S_RECOVER = 4'b1000
	} mode_t;
endpackage

// *** core/bit_sync.sv ***
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the destination clock is pclk.
`timescale 1ns/1ps
module bit_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	initial begin
		if (WIDTH < 1) begin
			$error("bit_sync width must be positive");
		end
	end

	// Free-running so a frozen clock enable never traps metastability
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				stage1[i] <= 1'b0;
				sync_out[i] <= 1'b0;
			end else begin
				stage1[i] <= async_in[i];
				sync_out[i] <= stage1[i];
			end
		end
	end
endmodule

// *** core/recovery_counter.sv ***
// Stop recovery timer counting reference clock ticks.
// Assumes tick is a one-cycle enable in the pclk domain.
`timescale 1ns/1ps
module recovery_counter
	import sis_pkg::*;
#(
	parameter int LONG_CYCLES = REC_LONG_CYCLES,
	parameter int SHORT_CYCLES = REC_SHORT_CYCLES,
	parameter int CNT_W = 13
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Control
	input wire logic hold,
	input wire logic tick,
	input wire logic use_short,
	// Status
	output logic done
);
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] last;

	initial begin
		if (SHORT_CYCLES < 1 || LONG_CYCLES < SHORT_CYCLES || LONG_CYCLES >= (1 << CNT_W)) begin
			$error("recovery_counter lengths do not fit");
		end
	end

	assign last = use_short ? CNT_W'(SHORT_CYCLES - 1) : CNT_W'(LONG_CYCLES - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
			done <= 1'b0;
		end else if (clk_en) begin
			if (hold) begin
				count <= '0;
				done <= 1'b0;
			end else if (tick && !done) begin
				count <= count + CNT_W'(1);
				done <= (count == last);
			end
		end
	end
endmodule

// *** core/system_interrupt_standby_control.sv ***
// Interrupt latch and arbitration, standby control and reset cause.
// Assumes CPU strobes are one-cycle pulses on pclk; the pin is async.
//
// Functional notes
// - Latch requests; hand CPU fixed winning vector
// - Latched request holds until serviced or unmasked
// - Arbitrate at instruction completion, wait wake, recovery end
// - Take only unmasked, enabled sources
// - Highest priority pending request wins
// - Pending request serviced right after return
// - Upper index register never pushed
// - Software trap ignores global mask
// - Software pushes PC; hardware pushes PC-1
// - Reset beats and bypasses arbitration
// - Wait/stop clear mask, gate CPU clock
// - Wait keeps peripherals; stack next cycle
// - Watchdog runs in wait unless disabled
// - Stop gates clocks, generator unless enabled
// - Counter held in stop, times recovery
// - Interrupt recovery 4096 or 32 ticks
// - Reset exit always uses long recovery
// - Separate flag per reset source
// - Read clears causes; power-on sets one
// - Used pending flags mirror enabled requests
// - Unused pending flags read zero
// - Mask spares software trap; fixed priorities
// - Timebase flag sets on rollover, ack clears
`timescale 1ns/1ps
module system_interrupt_standby_control
	import sis_pkg::*;
#(
	parameter int LONG_CYCLES = REC_LONG_CYCLES,
	parameter int SHORT_CYCLES = REC_SHORT_CYCLES
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sis_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// CPU core strobes
	input wire logic instr_done,
	input wire logic swi_exec,
	input wire logic wait_exec,
	input wire logic stop_exec,
	input wire logic int_ack,
	input wire logic global_mask,
	// Interrupt sources
	input wire logic external_interrupt_pin,
	input wire logic [sis_pkg::NUM_SRC-2:1] periph_req,
	input wire logic timebase_rollover,
	// Reset sources, watchdog through low voltage
	input wire logic [sis_pkg::RC_W-1:1] reset_req,
	// Reference clock tick
	input wire logic reference_clock,
	// To CPU
	output logic int_request,
	output logic [sis_pkg::PRI_W-1:0] int_vector_sel,
	output logic push_pc_minus_one,
	output logic push_index_high,
	output logic mask_clear,
	output logic cpu_reset,
	// Clock gating
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic clkgen_out_en,
	output logic watchdog_run
);
	import sis_pkg::*;

	mode_t mode;
	mode_t next_mode;
	logic pin_level;
	logic [RC_W-1:0] reset_cause_status;
	logic [2:0] config_bits;
	logic [NUM_SRC:1] src_enable;
	logic timebase_irq_enable;
	logic timebase_rollover_flag;
	logic [NUM_SRC:1] raw_req;
	logic [NUM_SRC:1] avail;
	logic any_avail;
	logic [PRI_W-1:0] winner;
	logic mask_prev;
	logic mask_fall;
	logic reset_any;
	logic rec_long;
	logic rec_by_reset;
	logic rec_done;
	logic xfer_setup;
	logic xfer_done;
	logic wr_done;
	logic rd_cause;
	logic [31:0] rd_word;
	logic rd_mapped;
	logic [7:0] pend_low;
	logic [7:0] pend_mid;
	logic [7:0] pend_high;

	bit_sync #(.WIDTH(1)) u_pin_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(external_interrupt_pin),
		.sync_out(pin_level)
	);

	// Counter held in reset outside recovery
	recovery_counter #(
		.LONG_CYCLES(LONG_CYCLES),
		.SHORT_CYCLES(SHORT_CYCLES),
		.CNT_W(13)
	) u_rec (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.hold(mode != S_RECOVER),
		.tick(reference_clock),
		.use_short(!rec_long),
		.done(rec_done)
	);

	assign reset_any = |reset_req;
	assign mask_fall = mask_prev && !global_mask;

	// Request vector, index equals fixed priority
	assign raw_req = {timebase_irq_enable && timebase_rollover_flag, periph_req, pin_level};
	assign avail = raw_req & src_enable;
	assign any_avail = |avail;

	// Lowest index wins
	always_comb begin
		winner = PRI_EXT_PIN;
		for (int i = NUM_SRC; i >= 1; i--) begin
			if (avail[i]) begin
				winner = PRI_W'(i);
			end
		end
	end

	// Pending flag layout: used flags mirror enabled requests, spare bits zero
	assign pend_low = {1'b0, avail[5:1], 2'b00};
	assign pend_mid = {avail[9:6], 4'h0};
	assign pend_high = {6'h00, avail[11:10]};

	always_comb begin
		next_mode = mode;
		case (mode)
			S_RUN: begin
				if (!reset_any && instr_done && wait_exec) begin
					next_mode = S_WAIT;
				end else if (!reset_any && instr_done && stop_exec) begin
					next_mode = S_STOP;
				end
			end
			S_WAIT: begin
				if (reset_any || any_avail) begin
					next_mode = S_RUN;
				end
			end
			S_STOP: begin
				if (reset_any || any_avail) begin
					next_mode = S_RECOVER;
				end
			end
			S_RECOVER: begin
				if (rec_done) begin
					next_mode = S_RUN;
				end
			end
			default: next_mode = S_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= S_RUN;
			mask_prev <= 1'b0;
		end else if (clk_en) begin
			mode <= next_mode;
			mask_prev <= global_mask;
		end
	end

	// Recovery length chosen on stop exit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rec_long <= 1'b1;
			rec_by_reset <= 1'b0;
		end else if (clk_en) begin
			if (mode == S_STOP && next_mode == S_RECOVER) begin
				rec_long <= reset_any || !config_bits[CFG_SHORT_REC];
				rec_by_reset <= reset_any;
			end else if (mode == S_RECOVER && reset_any) begin
				rec_long <= 1'b1;
				rec_by_reset <= 1'b1;
			end
		end
	end

	// Interrupt latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_request <= 1'b0;
			int_vector_sel <= PRI_SWI;
			push_pc_minus_one <= 1'b0;
			push_index_high <= 1'b0;
		end else if (clk_en) begin
			push_index_high <= 1'b0;
			if (reset_any) begin
				int_request <= 1'b0;
			end else if (int_request) begin
				// Nothing displaces the latched source
				if (int_ack || mask_fall) begin
					int_request <= 1'b0;
				end
			end else if (mode == S_RUN && instr_done) begin
				if (swi_exec) begin
					int_request <= 1'b1;
					int_vector_sel <= PRI_SWI;
					push_pc_minus_one <= 1'b0;
				end else if (!global_mask && any_avail && !wait_exec && !stop_exec) begin
					int_request <= 1'b1;
					int_vector_sel <= winner;
					push_pc_minus_one <= 1'b1;
				end
			end else if (mode == S_WAIT && any_avail) begin
				int_request <= 1'b1;
				int_vector_sel <= winner;
				push_pc_minus_one <= 1'b1;
			end else if (mode == S_RECOVER && rec_done && !rec_by_reset && any_avail) begin
				int_request <= 1'b1;
				int_vector_sel <= winner;
				push_pc_minus_one <= 1'b1;
			end
		end
	end

	// Clock gating and CPU controls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_clk_en <= 1'b1;
			periph_clk_en <= 1'b1;
			clkgen_out_en <= 1'b1;
			watchdog_run <= 1'b1;
			mask_clear <= 1'b0;
			cpu_reset <= 1'b0;
		end else if (clk_en) begin
			cpu_clk_en <= (next_mode == S_RUN);
			periph_clk_en <= (next_mode == S_RUN) || (next_mode == S_WAIT);
			// Recovery needs the reference clock to count
			clkgen_out_en <= (next_mode != S_STOP) || config_bits[CFG_OSC_IN_STOP];
			watchdog_run <= !config_bits[CFG_WD_DISABLE] && (next_mode != S_STOP);
			mask_clear <= (mode == S_RUN) && !reset_any && instr_done
				&& (wait_exec || stop_exec);
			// Reset from stop is held until the long recovery ends
			cpu_reset <= reset_any || (mode == S_RECOVER && rec_by_reset && !rec_done);
		end
	end

	// APB: answer on the second access cycle
	assign xfer_setup = psel && penable && !pready;
	assign xfer_done = psel && penable && pready;
	assign wr_done = xfer_done && pwrite;
	assign rd_cause = xfer_done && !pwrite && (paddr == OFS_RESET_CAUSE);

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_mapped = 1'b1;
		case (paddr)
			OFS_RESET_CAUSE: rd_word[RC_W-1:0] = reset_cause_status;
			OFS_PEND_LOW: rd_word[7:0] = pend_low;
			OFS_PEND_MID: rd_word[7:0] = pend_mid;
			OFS_PEND_HIGH: rd_word[7:0] = pend_high;
			OFS_CONFIG: rd_word[2:0] = config_bits;
			OFS_SRC_ENABLE: rd_word[NUM_SRC:1] = src_enable;
			OFS_TIMEBASE: begin
				rd_word[TB_IRQ_EN] = timebase_irq_enable;
				rd_word[TB_FLAG] = timebase_rollover_flag;
			end
			default: rd_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (clk_en) begin
			pready <= xfer_setup;
			if (xfer_setup) begin
				pslverr <= !rd_mapped;
				prdata <= pwrite ? 32'h0000_0000 : rd_word;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// Software writable controls; status registers ignore writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_bits <= 3'h0;
			src_enable <= '0;
			timebase_irq_enable <= 1'b0;
		end else if (clk_en && wr_done) begin
			case (paddr)
				OFS_CONFIG: config_bits <= pwdata[2:0];
				OFS_SRC_ENABLE: src_enable <= pwdata[NUM_SRC:1];
				OFS_TIMEBASE: timebase_irq_enable <= pwdata[TB_IRQ_EN];
				default: ;
			endcase
		end
	end

	// Timebase flag: rollover wins over a same-cycle acknowledge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timebase_rollover_flag <= 1'b0;
		end else if (clk_en) begin
			if (timebase_rollover) begin
				timebase_rollover_flag <= 1'b1;
			end else if (wr_done && paddr == OFS_TIMEBASE && pwdata[TB_ACK]) begin
				timebase_rollover_flag <= 1'b0;
			end
		end
	end

	// Reset cause: power-on sets only its own flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_cause_status <= RC_RESET_VAL;
		end else if (clk_en) begin
			if (reset_any) begin
				reset_cause_status <= {reset_req, 1'b0};
			end else if (rd_cause) begin
				reset_cause_status <= '0;
			end
		end
	end

	chk_swi_unmaskable: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && mode == S_RUN && instr_done && swi_exec && !int_request && !reset_any
		|=> int_request && int_vector_sel == PRI_SWI && !push_pc_minus_one)
		else $error("software trap not taken");
	chk_latch_holds: assert property (@(posedge pclk) disable iff (!presetn)
		int_request && !int_ack && !mask_fall && !reset_any
		|=> int_request && $stable(int_vector_sel))
		else $error("latched request displaced");
	chk_masked_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && mode == S_RUN && instr_done && global_mask && !swi_exec && !int_request
		|=> !int_request)
		else $error("masked request taken");
	chk_pc_adjust: assert property (@(posedge pclk) disable iff (!presetn)
		int_request |-> push_pc_minus_one == (int_vector_sel != PRI_SWI))
		else $error("stacked PC adjust wrong");
	chk_reset_first: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && reset_any |=> cpu_reset && !int_request ##1 !int_request)
		else $error("reset did not override interrupt");
	chk_wait_entry: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && mode == S_RUN && instr_done && wait_exec && !reset_any
		|=> mask_clear && !cpu_clk_en && periph_clk_en)
		else $error("wait entry wrong");
	chk_wait_wake: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && mode == S_WAIT && any_avail && !reset_any
		|=> int_request && cpu_clk_en)
		else $error("wait wake did not start stacking");
	chk_wait_watchdog: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && next_mode == S_WAIT |=> watchdog_run == !$past(config_bits[CFG_WD_DISABLE]))
		else $error("watchdog state wrong in wait");
	chk_stop_clocks: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && next_mode == S_STOP
		|=> !periph_clk_en && clkgen_out_en == $past(config_bits[CFG_OSC_IN_STOP]))
		else $error("stop clock gating wrong");
	chk_cause_read: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && rd_cause && !reset_any |=> reset_cause_status == '0)
		else $error("reset cause not cleared by read");
	chk_reset_long: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && mode == S_STOP && reset_any |=> rec_long)
		else $error("reset exit not long recovery");

	cov_swi: cover property (@(posedge pclk) disable iff (!presetn)
		int_request && int_vector_sel == PRI_SWI);
	cov_wait_wake: cover property (@(posedge pclk) disable iff (!presetn)
		mode == S_WAIT ##1 int_request);
	cov_stop_recover: cover property (@(posedge pclk) disable iff (!presetn)
		mode == S_RECOVER && rec_done);
	cov_cause_read: cover property (@(posedge pclk) disable iff (!presetn) rd_cause);
endmodule

// *** testbench/cpu_model.sv ***
// CPU core stand-in: finishes instructions on request, acknowledges interrupts.
// Assumes the bench pulses issue for one cycle, right after a rising edge.
`timescale 1ns/1ps
module cpu_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench control
	input wire logic issue,
	input wire logic [1:0] op,
	input wire logic [7:0] ack_delay,
	// Block side
	input wire logic cpu_clk_en,
	input wire logic int_request,
	output logic instr_done,
	output logic swi_exec,
	output logic wait_exec,
	output logic stop_exec,
	output logic int_ack
);
	logic [7:0] held;
	// A gated core finishes nothing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_done <= 1'b0;
			swi_exec <= 1'b0;
			wait_exec <= 1'b0;
			stop_exec <= 1'b0;
		end else begin
			instr_done <= issue && cpu_clk_en;
			swi_exec <= issue && op == 2'd1;
			wait_exec <= issue && op == 2'd2;
			stop_exec <= issue && op == 2'd3;
		end
	end
	// Slow service is a large ack_delay
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held <= 8'h00;
			int_ack <= 1'b0;
		end else begin
			held <= int_request ? held + 8'h01 : 8'h00;
			int_ack <= int_request && !int_ack && held >= ack_delay;
		end
	end
endmodule

// *** testbench/system_interrupt_standby_control_test.sv ***
// Self-checking bench for the interrupt and standby controller.
// Assumes short recovery counts so that stop exits stay brief.
`timescale 1ns/1ps
module system_interrupt_standby_control_test;
	import sis_pkg::*;
	localparam int LONG = 16;
	localparam int SHORT = 4;
	logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00, ack_delay = 8'hFF;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic pready, pslverr, instr_done, swi_exec, wait_exec, stop_exec, int_ack;
	logic issue = 0, global_mask = 0, external_interrupt_pin = 0, timebase_rollover = 0;
	logic [1:0] op = 2'b00;
	logic [9:1] periph_req = '0;
	logic [5:1] reset_req = '0;
	logic reference_clock = 0, saw_mclr = 0;
	logic int_request, push_pc_minus_one, push_index_high, mask_clear, cpu_reset;
	logic [3:0] int_vector_sel;
	logic cpu_clk_en, periph_clk_en, clkgen_out_en, watchdog_run;
	int mismatches = 0, check_count = 0, cycles = 0, n;

	system_interrupt_standby_control #(.LONG_CYCLES(LONG), .SHORT_CYCLES(SHORT))
	system_interrupt_standby_control_i (
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instr_done(instr_done), .swi_exec(swi_exec),
		.wait_exec(wait_exec), .stop_exec(stop_exec), .int_ack(int_ack),
		.global_mask(global_mask), .external_interrupt_pin(external_interrupt_pin),
		.periph_req(periph_req), .timebase_rollover(timebase_rollover),
		.reset_req(reset_req), .reference_clock(reference_clock),
		.int_request(int_request), .int_vector_sel(int_vector_sel),
		.push_pc_minus_one(push_pc_minus_one), .push_index_high(push_index_high),
		.mask_clear(mask_clear), .cpu_reset(cpu_reset), .cpu_clk_en(cpu_clk_en),
		.periph_clk_en(periph_clk_en), .clkgen_out_en(clkgen_out_en),
		.watchdog_run(watchdog_run));
	cpu_model cpu_model_i (.pclk(pclk), .presetn(presetn), .issue(issue), .op(op),
		.ack_delay(ack_delay), .cpu_clk_en(cpu_clk_en), .int_request(int_request),
		.instr_done(instr_done), .swi_exec(swi_exec), .wait_exec(wait_exec),
		.stop_exec(stop_exec), .int_ack(int_ack));

	always #2.5 pclk = ~pclk;
	// Tick every other cycle so recovery is not just a cycle count
	always @(posedge pclk) begin
		reference_clock <= !reference_clock;
		if (mask_clear === 1'b1) begin
			saw_mclr <= 1'b1;
		end
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			conclude();
		end
	end

	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	// Called right after a rising edge; returns right after one
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		// Look mid-cycle so the answer has settled
		do begin
			@(negedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 40);
		if (k >= 40) begin
			mismatches++;
		end
		r = prdata;
		e = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		check(r, exp);
	endtask
	task automatic run_instr(input logic [1:0] o);
		issue <= 1'b1;
		op <= o;
		@(posedge pclk);
		issue <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	task automatic ack;
		ack_delay <= 8'h00;
		repeat (3) @(posedge pclk);
		check(int_request, 1'b0);
		ack_delay <= 8'hFF;
		@(posedge pclk);
	endtask
	task automatic count_run(output int c);
		c = 0;
		while (cpu_clk_en !== 1'b1 && c < 500) begin
			@(posedge pclk);
			c++;
		end
	endtask

	task automatic t_reset_cause;
		rd(OFS_RESET_CAUSE, 32'h0000_0001);
		rd(OFS_RESET_CAUSE, 32'h0000_0000);
		for (int i = 1; i < 6; i++) begin
			reset_req <= 5'(1 << (i - 1));
			@(posedge pclk);
			reset_req <= '0;
			@(posedge pclk);
			wr(OFS_RESET_CAUSE, 32'h0000_003F);
			rd(OFS_RESET_CAUSE, 32'(1 << i));
		end
	endtask
	task automatic t_pending_map;
		logic [31:0] r;
		logic e;
		wr(OFS_SRC_ENABLE, 32'h0000_0FFE);
		external_interrupt_pin <= 1'b1;
		periph_req <= '1;
		repeat (4) @(posedge pclk);
		wr(OFS_PEND_LOW, 32'h0000_00FF);
		rd(OFS_PEND_LOW, 32'h0000_007C);
		rd(OFS_PEND_MID, 32'h0000_00F0);
		rd(OFS_PEND_HIGH, 32'h0000_0001);
		apb(1'b0, 8'h1C, 32'h0000_0000, r, e);
		check(e, 1'b1);
		external_interrupt_pin <= 1'b0;
		periph_req <= '0;
		repeat (4) @(posedge pclk);
	endtask
	task automatic t_arbitration;
		periph_req <= 9'h00A;
		repeat (5) @(posedge pclk);
		check(int_request, 1'b0);
		rd(OFS_PEND_LOW, 32'h0000_0050);
		run_instr(2'd0);
		check(int_request, 1'b1);
		check(int_vector_sel, 4'h3);
		check(push_pc_minus_one, 1'b1);
		check(push_index_high, 1'b0);
		external_interrupt_pin <= 1'b1;
		repeat (3) @(posedge pclk);
		run_instr(2'd0);
		check(int_vector_sel, 4'h3);
		ack();
		run_instr(2'd0);
		check(int_vector_sel, PRI_EXT_PIN);
		ack();
		external_interrupt_pin <= 1'b0;
	endtask
	task automatic t_masking;
		global_mask <= 1'b1;
		run_instr(2'd0);
		check(int_request, 1'b0);
		run_instr(2'd1);
		check(int_request, 1'b1);
		check(int_vector_sel, PRI_SWI);
		check(push_pc_minus_one, 1'b0);
		ack();
		global_mask <= 1'b0;
		wr(OFS_SRC_ENABLE, 32'h0000_0000);
		run_instr(2'd0);
		check(int_request, 1'b0);
		wr(OFS_SRC_ENABLE, 32'h0000_0FFE);
		periph_req <= '0;
	endtask
	task automatic t_timebase;
		wr(OFS_TIMEBASE, 32'h0000_0001);
		timebase_rollover <= 1'b1;
		@(posedge pclk);
		timebase_rollover <= 1'b0;
		@(posedge pclk);
		rd(OFS_TIMEBASE, 32'h0000_0005);
		rd(OFS_PEND_HIGH, 32'h0000_0002);
		wr(OFS_TIMEBASE, 32'h0000_0003);
		rd(OFS_TIMEBASE, 32'h0000_0001);
		rd(OFS_PEND_HIGH, 32'h0000_0000);
	endtask
	task automatic t_wait;
		run_instr(2'd2);
		check(cpu_clk_en, 1'b0);
		check(saw_mclr, 1'b1);
		check(periph_clk_en, 1'b1);
		check(watchdog_run, 1'b1);
		periph_req[5] <= 1'b1;
		repeat (3) @(posedge pclk);
		check(int_request, 1'b1);
		check(cpu_clk_en, 1'b1);
		check(int_vector_sel, 4'h6);
		ack();
		periph_req <= '0;
	endtask
	task automatic t_stop;
		wr(OFS_CONFIG, 32'h0000_0004);
		run_instr(2'd3);
		check({cpu_clk_en, periph_clk_en, clkgen_out_en}, 3'b000);
		periph_req[2] <= 1'b1;
		count_run(n);
		check(32'(n >= 2 * SHORT - 2 && n <= 2 * SHORT + 6), 1);
		repeat (2) @(posedge pclk);
		check(int_request, 1'b1);
		check(int_vector_sel, 4'h3);
		ack();
		periph_req <= '0;
		wr(OFS_CONFIG, 32'h0000_0006);
		run_instr(2'd3);
		check(clkgen_out_en, 1'b1);
		reset_req <= 5'h01;
		@(posedge pclk);
		reset_req <= '0;
		count_run(n);
		check(32'(n >= 2 * LONG - 3 && n <= 2 * LONG + 6), 1);
		repeat (4) @(posedge pclk);
	endtask
	task automatic t_reset_priority;
		global_mask <= 1'b1;
		run_instr(2'd1);
		check(int_request, 1'b1);
		reset_req <= 5'h10;
		@(posedge pclk);
		reset_req <= '0;
		repeat (2) @(posedge pclk);
		check(int_request, 1'b0);
	endtask

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset_cause();
		t_pending_map();
		t_arbitration();
		t_masking();
		t_timebase();
		t_wait();
		t_stop();
		t_reset_priority();
		conclude();
	end
endmodule
